// ===== include/srj_pkg.sv
/*
  Shared constants and carriers for the shift, rotate and jump execution unit.
  Assumes the fetch logic hands over all instruction bytes at once.
*/
`default_nettype none
package srj_pkg;

  // ---------------------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PREFIX_BYTE   = 8'h48;
  localparam logic [7:0] OPC_ABS_JUMP  = 8'h54;
  localparam logic [7:0] OPC_PAIR_JUMP = 8'h21;
  localparam logic [1:0] OPC_REL_TOP   = 2'h3;
  // Second byte: upper six bits for byte forms, low two bits carry the register select; whole byte for wide forms
  localparam logic [5:0] OPC2_BYTE_ROR    = 6'h0C;
  localparam logic [5:0] OPC2_BYTE_SHL    = 6'h09;
  localparam logic [5:0] OPC2_BYTE_SHR    = 6'h08;
  localparam logic [5:0] OPC2_BYTE_SHL_SK = 6'h01;
  localparam logic [5:0] OPC2_BYTE_SHR_SK = 6'h00;
  localparam logic [7:0] OPC2_WIDE_ROL    = 8'hB4;
  localparam logic [7:0] OPC2_WIDE_ROR    = 8'hB0;
  localparam logic [7:0] OPC2_WIDE_SHL    = 8'hA4;
  localparam logic [7:0] OPC2_WIDE_SHR    = 8'hA0;

  // ---------------------------------------------------------------------------
  // Timing in states, one state per clock
  // ---------------------------------------------------------------------------
  localparam int         CNT_W        = 4;
  localparam logic [3:0] SHIFT_STATES = 4'h8;
  localparam logic [3:0] ABS_STATES   = 4'hA;
  localparam logic [3:0] PAIR_STATES  = 4'h4;
  localparam logic [3:0] REL_STATES   = 4'hA;
  localparam logic [3:0] CNT_RESET    = 4'h0;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SH_ROL = 2'h0,
    SH_ROR = 2'h1,
    SH_SHL = 2'h2,
    SH_SHR = 2'h3
  } srj_shift_t;

  typedef enum logic [3:0] {
    OP_NONE        = 4'h0,
    OP_BYTE_ROR    = 4'h1,
    OP_BYTE_SHL    = 4'h2,
    OP_BYTE_SHR    = 4'h3,
    OP_BYTE_SHL_SK = 4'h4,
    OP_BYTE_SHR_SK = 4'h5,
    OP_WIDE_ROL    = 4'h6,
    OP_WIDE_ROR    = 4'h7,
    OP_WIDE_SHL    = 4'h8,
    OP_WIDE_SHR    = 4'h9,
    OP_ABS_JUMP    = 4'hA,
    OP_PAIR_JUMP   = 4'hB,
    OP_REL_JUMP    = 4'hC
  } srj_op_t;

  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
  } srj_instr_t;

  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  c;
    logic [15:0] ea;
    logic [15:0] pc;
    logic        cy;
  } srj_opnd_t;

  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  c;
    logic [15:0] ea;
    logic [15:0] pc;
    logic        cy;
    logic        skip;
    logic        chain_hi;
    logic        chain_lo;
    logic        wr_a;
    logic        wr_b;
    logic        wr_c;
    logic        wr_ea;
    logic        wr_pc;
    logic        wr_cy;
  } srj_result_t;

  localparam srj_result_t RESULT_RESET = '0;

endpackage
`default_nettype wire

// ===== hw/srj_shifter.sv
/*
  One-bit shifter and rotator through carry, width set by parameter.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module srj_shifter
  import srj_pkg::*;
#(
  parameter int W = 8
) (
  // Operand
  input  wire logic [W-1:0] value_in,
  input  wire logic         carry_in,
  input  wire srj_shift_t   mode,
  // Result
  output logic [W-1:0]      value_out,
  output logic              carry_out
);

  always_comb begin
    value_out = value_in;
    carry_out = carry_in;
    case (mode)
      SH_ROL: begin
        value_out = {value_in[W-2:0], carry_in};
        carry_out = value_in[W-1];
      end
      SH_ROR: begin
        value_out = {carry_in, value_in[W-1:1]};
        carry_out = value_in[0];
      end
      SH_SHL: begin
        value_out = {value_in[W-2:0], 1'b0};
        carry_out = value_in[W-1];
      end
      SH_SHR: begin
        value_out = {1'b0, value_in[W-1:1]};
        carry_out = value_in[0];
      end
      default: begin
        value_out = value_in;
        carry_out = carry_in;
      end
    endcase
  end

endmodule
`default_nettype wire

// ===== hw/srj_exec.sv
/*
  Execution unit for byte and wide shifts and rotates and for three jumps.
  Assumes the core presents all instruction bytes and a snapshot of the
  operand registers together with a one-cycle start, and writes back the
  result fields whose write enables are set when done pulses.
*/
// Functional notes
// [RULE1] Byte rotate right through carry on A, B or C chosen by select 1 to 3.
// [RULE2] Byte left shift: bit 7 to carry, zero into bit 0, both forms.
// [RULE3] Byte right shift: bit 0 to carry, zero into bit 7, both forms.
// [RULE4] Skip forms skip the next instruction when the shifted-out bit is one.
// [RULE5] Skip forms set skip from the shift, clear chain flags, update carry.
// [RULE6] Wide rotate left through carry: top bit to carry, carry into bit 0.
// [RULE7] Wide rotate right through carry: bit 0 to carry, carry into bit 15.
// [RULE8] Wide left shift: bit 15 to carry, zero into bit 0.
// [RULE9] Wide right shift: bit 0 to carry, zero into bit 15.
// [RULE10] Absolute jump, three bytes, ten states: byte 2 low, byte 3 high.
// [RULE11] Pair jump, one byte, four states: B to high, C to low.
// [RULE12] Relative jump adds signed six-bit displacement to next address.
// [RULE13] Non-skip forms clear skip and chain flags; shifts also update carry.
// [RULE14] Shifts and rotates: two bytes, common prefix, eight states each.
`timescale 1ns/1ps
`default_nettype none
module srj_exec
  import srj_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ce,
  // Request
  input  wire logic       start,
  input  wire srj_instr_t instr,
  input  wire srj_opnd_t  opnd,
  output logic            ready,
  // Answer
  output logic            done,
  output logic            illegal,
  output srj_result_t     result
);

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------
  function automatic srj_op_t decode_op(input srj_instr_t ins);
    srj_op_t op;
    op = OP_NONE;
    if (ins.b1 == PREFIX_BYTE) begin
      if (ins.b2[1:0] != 2'h0) begin
        case (ins.b2[7:2])
          OPC2_BYTE_ROR:    op = OP_BYTE_ROR;
          OPC2_BYTE_SHL:    op = OP_BYTE_SHL;
          OPC2_BYTE_SHR:    op = OP_BYTE_SHR;
          OPC2_BYTE_SHL_SK: op = OP_BYTE_SHL_SK;
          OPC2_BYTE_SHR_SK: op = OP_BYTE_SHR_SK;
          default:          op = OP_NONE;
        endcase
      end
      case (ins.b2)
        OPC2_WIDE_ROL: op = OP_WIDE_ROL;
        OPC2_WIDE_ROR: op = OP_WIDE_ROR;
        OPC2_WIDE_SHL: op = OP_WIDE_SHL;
        OPC2_WIDE_SHR: op = OP_WIDE_SHR;
        default:       op = op;
      endcase
    end else if (ins.b1 == OPC_ABS_JUMP) begin
      op = OP_ABS_JUMP;
    end else if (ins.b1 == OPC_PAIR_JUMP) begin
      op = OP_PAIR_JUMP;
    end else if (ins.b1[7:6] == OPC_REL_TOP) begin
      op = OP_REL_JUMP;
    end
    return op;
  endfunction

  // Select 1 = A, 2 = B, 3 = C; zero, carried by wide and illegal codes, falls to A
  function automatic logic [7:0] sel_byte(input srj_opnd_t o, input logic [1:0] sel);
    logic [7:0] v;
    v = o.a;
    case (sel)
      2'h2:    v = o.b;
      2'h3:    v = o.c;
      default: v = o.a;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------------------
  srj_op_t     dec_op;
  logic [1:0]  dec_sel;
  srj_shift_t  byte_mode;
  srj_shift_t  wide_mode;
  logic [7:0]  byte_out;
  logic        byte_cy;
  logic [15:0] wide_out;
  logic        wide_cy;
  srj_result_t calc;
  logic [3:0]  calc_states;

  assign dec_op  = decode_op(instr);
  assign dec_sel = instr.b2[1:0];

  always_comb begin
    byte_mode = SH_ROR;                                     // RULE1
    case (dec_op)
      OP_BYTE_SHL, OP_BYTE_SHL_SK: byte_mode = SH_SHL;      // RULE2
      OP_BYTE_SHR, OP_BYTE_SHR_SK: byte_mode = SH_SHR;      // RULE3
      default:                     byte_mode = SH_ROR;
    endcase
    wide_mode = SH_ROL;                                     // RULE6
    case (dec_op)
      OP_WIDE_ROR: wide_mode = SH_ROR;                      // RULE7
      OP_WIDE_SHL: wide_mode = SH_SHL;                      // RULE8
      OP_WIDE_SHR: wide_mode = SH_SHR;                      // RULE9
      default:     wide_mode = SH_ROL;
    endcase
  end

  srj_shifter #(.W(8)) u_byte_shift (
    .value_in  (sel_byte(opnd, dec_sel)),
    .carry_in  (opnd.cy),
    .mode      (byte_mode),
    .value_out (byte_out),
    .carry_out (byte_cy)
  );

  srj_shifter #(.W(16)) u_wide_shift (
    .value_in  (opnd.ea),
    .carry_in  (opnd.cy),
    .mode      (wide_mode),
    .value_out (wide_out),
    .carry_out (wide_cy)
  );

  always_comb begin
    calc        = RESULT_RESET;                             // RULE13
    calc.a      = opnd.a;
    calc.b      = opnd.b;
    calc.c      = opnd.c;
    calc.ea     = opnd.ea;
    calc.pc     = opnd.pc;
    calc.cy     = opnd.cy;
    calc_states = SHIFT_STATES;                             // RULE14
    case (dec_op)
      OP_BYTE_ROR, OP_BYTE_SHL, OP_BYTE_SHR, OP_BYTE_SHL_SK, OP_BYTE_SHR_SK: begin
        // Only the selected register changes; the others keep the operand copy
        case (dec_sel)
          2'h2:    calc.b = byte_out;
          2'h3:    calc.c = byte_out;
          default: calc.a = byte_out;
        endcase
        calc.wr_a  = (dec_sel == 2'h1);                     // RULE1
        calc.wr_b  = (dec_sel == 2'h2);
        calc.wr_c  = (dec_sel == 2'h3);
        calc.cy    = byte_cy;
        calc.wr_cy = 1'b1;
        // Skip forms keep the shifted-out bit as the skip request
        calc.skip  = byte_cy && (dec_op == OP_BYTE_SHL_SK || dec_op == OP_BYTE_SHR_SK); // RULE4 RULE5
      end
      OP_WIDE_ROL, OP_WIDE_ROR, OP_WIDE_SHL, OP_WIDE_SHR: begin
        calc.ea    = wide_out;
        calc.wr_ea = 1'b1;
        calc.cy    = wide_cy;
        calc.wr_cy = 1'b1;
      end
      OP_ABS_JUMP: begin
        calc.pc     = {instr.b3, instr.b2};                 // RULE10
        calc.wr_pc  = 1'b1;
        calc_states = ABS_STATES;
      end
      OP_PAIR_JUMP: begin
        calc.pc     = {opnd.b, opnd.c};                     // RULE11
        calc.wr_pc  = 1'b1;
        calc_states = PAIR_STATES;
      end
      OP_REL_JUMP: begin
        // Wraps modulo 64K, as the program counter does
        calc.pc     = opnd.pc + 16'h0001 + {{10{instr.b1[5]}}, instr.b1[5:0]}; // RULE12
        calc.wr_pc  = 1'b1;
        calc_states = REL_STATES;
      end
      default: begin
        calc_states = CNT_RESET;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_RUN  = 2'h2
  } srj_state_t;

  srj_state_t  state;
  srj_state_t  next_state;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  srj_result_t next_result;
  logic        next_illegal;
  logic        take;

  assign take  = ce && start && (state == ST_IDLE);
  assign ready = (state == ST_IDLE);
  assign done  = (state == ST_RUN) && (cnt == CNT_RESET);

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_result  = result;
    next_illegal = illegal;
    case (state)
      ST_IDLE: begin
        if (take) begin
          // Illegal codes are answered at once and leave the core state alone
          next_illegal = (dec_op == OP_NONE);
          if (dec_op != OP_NONE) begin
            next_result = calc;
            next_cnt    = calc_states - 4'h1;               // RULE10 RULE11 RULE14
            next_state  = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (ce) begin
          if (cnt == CNT_RESET) begin
            next_state = ST_IDLE;
          end else begin
            next_cnt = cnt - 4'h1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state   <= ST_IDLE;
      cnt     <= CNT_RESET;
      result  <= RESULT_RESET;
      illegal <= 1'b0;
    end else if (ce) begin
      state   <= next_state;
      cnt     <= next_cnt;
      result  <= next_result;
      illegal <= next_illegal;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  srj_op_t    chk_op;
  srj_opnd_t  chk_opnd;
  logic [1:0] chk_sel;
  logic [7:0] chk_b2;
  logic [7:0] chk_b3;
  logic [3:0] elapsed;
  logic [7:0] chk_old;
  logic [7:0] chk_new;

  // Result carrier is wider than the operand carrier, so it needs its own pick
  function automatic logic [7:0] res_byte(input srj_result_t r, input logic [1:0] sel);
    logic [7:0] v;
    v = r.a;
    case (sel)
      2'h2:    v = r.b;
      2'h3:    v = r.c;
      default: v = r.a;
    endcase
    return v;
  endfunction

  assign chk_old = sel_byte(chk_opnd, chk_sel);
  assign chk_new = res_byte(result, chk_sel);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chk_op   <= OP_NONE;
      chk_opnd <= '0;
      chk_sel  <= 2'h0;
      chk_b2   <= 8'h00;
      chk_b3   <= 8'h00;
      elapsed  <= CNT_RESET;
    end else if (ce) begin
      if (take) begin
        chk_op   <= dec_op;
        chk_opnd <= opnd;
        chk_sel  <= dec_sel;
        chk_b2   <= instr.b2;
        chk_b3   <= instr.b3;
        elapsed  <= CNT_RESET;
      end else if (state == ST_RUN) begin
        elapsed <= elapsed + 4'h1;
      end
    end
  end

  property p_byte_ror;
    @(posedge clock) disable iff (rst)
    done && chk_op == OP_BYTE_ROR |->
      chk_new == {chk_opnd.cy, chk_old[7:1]}
      && result.cy == chk_old[0];
  endproperty
  a_byte_ror: assert property (p_byte_ror) else $error("byte rotate right wrong"); // RULE1

  property p_byte_shl;
    @(posedge clock) disable iff (rst)
    done && (chk_op == OP_BYTE_SHL || chk_op == OP_BYTE_SHL_SK) |->
      chk_new == {chk_old[6:0], 1'b0}
      && result.cy == chk_old[7];
  endproperty
  a_byte_shl: assert property (p_byte_shl) else $error("byte left shift wrong"); // RULE2

  property p_byte_shr;
    @(posedge clock) disable iff (rst)
    done && (chk_op == OP_BYTE_SHR || chk_op == OP_BYTE_SHR_SK) |->
      chk_new == {1'b0, chk_old[7:1]}
      && result.cy == chk_old[0];
  endproperty
  a_byte_shr: assert property (p_byte_shr) else $error("byte right shift wrong"); // RULE3

  property p_skip_set;
    @(posedge clock) disable iff (rst)
    done && (chk_op == OP_BYTE_SHL_SK || chk_op == OP_BYTE_SHR_SK) |->
      result.skip == ((chk_op == OP_BYTE_SHL_SK) ? chk_old[7] : chk_old[0]);
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip does not follow carry out"); // RULE4

  property p_skip_flags;
    @(posedge clock) disable iff (rst)
    done && (chk_op == OP_BYTE_SHL_SK || chk_op == OP_BYTE_SHR_SK) |->
      !result.chain_hi && !result.chain_lo && result.wr_cy;
  endproperty
  a_skip_flags: assert property (p_skip_flags) else $error("skip form flags wrong"); // RULE5

  property p_wide_rol;
    @(posedge clock) disable iff (rst)
    done && chk_op == OP_WIDE_ROL |->
      result.ea == {chk_opnd.ea[14:0], chk_opnd.cy} && result.cy == chk_opnd.ea[15];
  endproperty
  a_wide_rol: assert property (p_wide_rol) else $error("wide rotate left wrong"); // RULE6

  property p_wide_ror;
    @(posedge clock) disable iff (rst)
    done && chk_op == OP_WIDE_ROR |->
      result.ea == {chk_opnd.cy, chk_opnd.ea[15:1]} && result.cy == chk_opnd.ea[0];
  endproperty
  a_wide_ror: assert property (p_wide_ror) else $error("wide rotate right wrong"); // RULE7

  property p_wide_shl;
    @(posedge clock) disable iff (rst)
    done && chk_op == OP_WIDE_SHL |->
      result.ea == {chk_opnd.ea[14:0], 1'b0} && result.cy == chk_opnd.ea[15];
  endproperty
  a_wide_shl: assert property (p_wide_shl) else $error("wide left shift wrong"); // RULE8

  property p_wide_shr;
    @(posedge clock) disable iff (rst)
    done && chk_op == OP_WIDE_SHR |->
      result.ea == {1'b0, chk_opnd.ea[15:1]} && result.cy == chk_opnd.ea[0];
  endproperty
  a_wide_shr: assert property (p_wide_shr) else $error("wide right shift wrong"); // RULE9

  property p_abs_jump;
    @(posedge clock) disable iff (rst)
    done && chk_op == OP_ABS_JUMP |->
      result.pc == {chk_b3, chk_b2} && elapsed == ABS_STATES - 4'h1;
  endproperty
  a_abs_jump: assert property (p_abs_jump) else $error("absolute jump wrong"); // RULE10

  property p_pair_jump;
    @(posedge clock) disable iff (rst)
    done && chk_op == OP_PAIR_JUMP |->
      result.pc == {chk_opnd.b, chk_opnd.c} && elapsed == PAIR_STATES - 4'h1;
  endproperty
  a_pair_jump: assert property (p_pair_jump) else $error("pair jump wrong"); // RULE11

  property p_rel_jump;
    @(posedge clock) disable iff (rst)
    take && dec_op == OP_REL_JUMP |=>
      $signed(result.pc - $past(opnd.pc) - 16'h0001) == $signed({{10{$past(instr.b1[5])}}, $past(instr.b1[5:0])});
  endproperty
  a_rel_jump: assert property (p_rel_jump) else $error("relative jump target wrong"); // RULE12

  property p_flags_clear;
    @(posedge clock) disable iff (rst)
    done && chk_op != OP_BYTE_SHL_SK && chk_op != OP_BYTE_SHR_SK |->
      !result.skip && !result.chain_hi && !result.chain_lo;
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared"); // RULE13

  property p_shift_time;
    @(posedge clock) disable iff (rst)
    done && result.wr_cy |-> elapsed == SHIFT_STATES - 4'h1;
  endproperty
  a_shift_time: assert property (p_shift_time) else $error("shift state count wrong"); // RULE14

endmodule
`default_nettype wire

// ===== dv/srj_tb.sv
/*
  Self-checking bench for the shift, rotate and jump execution unit.
  Assumes srj_pkg is compiled first; the bench drives every input itself.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import srj_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic        clock;
  logic        rst;
  logic        ce;
  logic        start;
  srj_instr_t  instr;
  srj_opnd_t   opnd;
  logic        ready;
  logic        done;
  logic        illegal;
  srj_result_t result;
  srj_result_t exp;
  int          errors;
  int          n_tests;

  srj_exec dut (
    .clock   (clock),
    .rst     (rst),
    .ce      (ce),
    .start   (start),
    .instr   (instr),
    .opnd    (opnd),
    .ready   (ready),
    .done    (done),
    .illegal (illegal),
    .result  (result)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [79:0] got, input logic [79:0] want);
    n_tests++;
    if (got !== want) begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask

  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic srj_result_t base(input srj_opnd_t o);
    srj_result_t r;
    r = RESULT_RESET;
    r.a = o.a;
    r.b = o.b;
    r.c = o.c;
    r.ea = o.ea;
    r.pc = o.pc;
    r.cy = o.cy;
    return r;
  endfunction

  // One instruction: hold cycles of ce low after cycle 0, keep holds a refused start
  task automatic exec(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3,
                      input int n, input int hold, input logic keep);
    int k;
    start = 1'b1;
    instr = '{b1: b1, b2: b2, b3: b3};
    @(posedge clock);
    @(negedge clock);
    start = keep;
    if (keep) begin
      instr = '{b1: PREFIX_BYTE, b2: OPC2_WIDE_SHL, b3: 8'h00};
    end
    for (k = 0; k < 40; k++) begin
      ce = (k < 1 || k > hold);
      #1;
      if (k == 0) begin
        chk({ready, illegal}, 2'b00);
      end
      if (done === 1'b1) begin
        break;
      end
      @(negedge clock);
    end
    chk(80'(k), 80'(n - 1 + hold));
    chk(result, exp);
    start = 1'b0;
    @(negedge clock);
    chk({done, ready}, 2'b01);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_byte();
    logic [5:0] codes [5];
    logic [7:0] vals [2];
    logic [7:0] v;
    logic [7:0] r;
    logic       o;
    codes = '{OPC2_BYTE_ROR, OPC2_BYTE_SHL, OPC2_BYTE_SHR, OPC2_BYTE_SHL_SK, OPC2_BYTE_SHR_SK};
    vals = '{8'h81, 8'h7E};
    for (int op = 0; op < 5; op++) begin
      for (int s = 1; s < 4; s++) begin
        for (int i = 0; i < 2; i++) begin
          v = vals[i];
          opnd = '{a: 8'h11, b: 8'h22, c: 8'h33, ea: 16'h4455, pc: 16'h6677, cy: i[0]};
          case (op)
            0: {r, o} = {opnd.cy, v};
            1, 3: {o, r} = {v, 1'b0};
            default: {r, o} = {1'b0, v};
          endcase
          case (s)
            1: opnd.a = v;
            2: opnd.b = v;
            default: opnd.c = v;
          endcase
          exp = base(opnd);
          case (s)
            1: {exp.a, exp.wr_a} = {r, 1'b1};
            2: {exp.b, exp.wr_b} = {r, 1'b1};
            default: {exp.c, exp.wr_c} = {r, 1'b1};
          endcase
          exp.cy = o;
          exp.wr_cy = 1'b1;
          exp.skip = (op >= 3) ? o : 1'b0;
          exec(PREFIX_BYTE, {codes[op], s[1:0]}, 8'hFF, 8, 0, 1'b0);
        end
      end
    end
  endtask

  task automatic t_wide();
    logic [7:0]  codes [4];
    logic [15:0] vals [2];
    logic [15:0] v;
    logic [15:0] r;
    logic        o;
    codes = '{OPC2_WIDE_ROL, OPC2_WIDE_ROR, OPC2_WIDE_SHL, OPC2_WIDE_SHR};
    vals = '{16'h8001, 16'h7FFE};
    for (int op = 0; op < 4; op++) begin
      for (int i = 0; i < 2; i++) begin
        v = vals[i];
        opnd = '{a: 8'hA1, b: 8'hB2, c: 8'hC3, ea: v, pc: 16'h0100, cy: i[0]};
        case (op)
          0: {o, r} = {v, opnd.cy};
          1: {r, o} = {opnd.cy, v};
          2: {o, r} = {v, 1'b0};
          default: {r, o} = {1'b0, v};
        endcase
        exp = base(opnd);
        exp.ea = r;
        exp.cy = o;
        exp.wr_ea = 1'b1;
        exp.wr_cy = 1'b1;
        exec(PREFIX_BYTE, codes[op], 8'hFF, 8, 0, 1'b0);
      end
    end
  endtask

  task automatic t_jump();
    logic [15:0] pcs [3];
    logic [15:0] tgt [3];
    logic [5:0]  d [3];
    pcs = '{16'hFFF0, 16'h0010, 16'h1000};
    d = '{6'h1F, 6'h20, 6'h3D};
    // Hand-worked targets, both wrap directions included
    tgt = '{16'h0010, 16'hFFF1, 16'h0FFE};
    opnd = '{a: 8'h01, b: 8'hBE, c: 8'hEF, ea: 16'h1234, pc: 16'h2000, cy: 1'b1};
    exp = base(opnd);
    exp.pc = 16'hC0DE;
    exp.wr_pc = 1'b1;
    exec(OPC_ABS_JUMP, 8'hDE, 8'hC0, 10, 0, 1'b0);
    exp.pc = 16'hBEEF;
    // Stalled by ce and hit by a start while busy
    exec(OPC_PAIR_JUMP, 8'h00, 8'h00, 4, 2, 1'b1);
    for (int i = 0; i < 3; i++) begin
      opnd.pc = pcs[i];
      exp = base(opnd);
      exp.pc = tgt[i];
      exp.wr_pc = 1'b1;
      exec({OPC_REL_TOP, d[i]}, 8'h00, 8'h00, 10, 0, 1'b0);
    end
  endtask

  task automatic t_illegal();
    for (int k = 0; k < 2; k++) begin
      start = 1'b1;
      instr = '{b1: k ? 8'h00 : PREFIX_BYTE, b2: {OPC2_BYTE_SHL, 2'h0}, b3: 8'h00};
      @(posedge clock);
      @(negedge clock);
      start = 1'b0;
      #1;
      chk({illegal, ready, done}, 3'b110);
      chk(result, exp);
      @(negedge clock);
    end
  endtask

  task automatic t_reset();
    start = 1'b1;
    instr = '{b1: PREFIX_BYTE, b2: OPC2_WIDE_ROL, b3: 8'h00};
    @(posedge clock);
    @(negedge clock);
    start = 1'b0;
    @(negedge clock);
    rst = 1'b1;
    #1;
    chk({ready, done, illegal}, 3'b100);
    chk(result, RESULT_RESET);
    @(negedge clock);
    rst = 1'b0;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    ce = 1'b1;
    start = 1'b0;
    instr = '0;
    opnd = '0;
    exp = RESULT_RESET;
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_byte();
    t_wide();
    t_jump();
    t_illegal();
    t_reset();
    t_jump();
    test_done();
  end

  // Whole run is well under 1000 cycles; this margin only catches a hang
  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
